//--- hdl/etg_fifo.sv
`timescale 1ns/1ps
module etg_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rp_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        wp_d  = push ? wp_q + 1'b1 : wp_q;
        rp_d  = pop ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
        if (push) begin
            mem_q[wp_q] <= in_data_i;
        end
    end

    fifo_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cnt_q <= DEPTH[AW:0])
        else $error("fifo count beyond depth");
endmodule : etg_fifo

//--- hdl/etg_pkg.sv
package etg_pkg;
    typedef enum logic [1:0] {
        ETG_IDLE = 2'b00,
        ETG_HDR  = 2'b01,
        ETG_PAY  = 2'b10
    } etg_state_t;
    typedef logic [9:0] etg_word_t; // data 8, sof, eof
endpackage : etg_pkg

//--- hdl/etg_regs.svh
`ifndef ETG_REGS_SVH
`define ETG_REGS_SVH
`define ETG_OFS_COUNT     8'h00
`define ETG_OFS_SHAPE     8'h04
`define ETG_OFS_SEED_LO   8'h08
`define ETG_OFS_SEED_HI   8'h0c
`define ETG_OFS_SRC_LO    8'h10
`define ETG_OFS_SRC_HI    8'h14
`define ETG_OFS_DST_LO    8'h18
`define ETG_OFS_DST_HI    8'h1c
`define ETG_OFS_CTRL      8'h20
`define ETG_OFS_SENT      8'h24
`define ETG_BIT_LEN_SEL   0
`define ETG_BIT_PAT_SEL   15
`define ETG_CTRL_START    0
`define ETG_CTRL_STOP     1
`define ETG_CTRL_BUSY     2
`define ETG_RST_WORD      32'h0000_0000
`define ETG_LEN_MIN       14'h0018
`define ETG_LEN_RAND_MAX  14'h05ee
`define ETG_LEN_RAND_SPAN 14'h05d7
`define ETG_HDR_BYTES     14'h000c
`define ETG_FIFO_DEPTH    16
`endif

//--- hdl/etg_top.sv
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`include "etg_regs.svh"
module etg_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // byte stream toward the mac
    output logic             tx_valid_o,
    input  wire logic        tx_ready_i,
    output logic      [7:0]  tx_data_o,
    output logic             tx_sof_o,
    output logic             tx_eof_o,
    output logic             busy_o
);
    logic [31:0] count_q, count_d, shape_q, shape_d, seedl_q, seedl_d;
    logic [15:0] seedh_q, seedh_d, srch_q, srch_d, dsth_q, dsth_d;
    logic [31:0] srcl_q, srcl_d, dstl_q, dstl_d, sent_q, sent_d;
    logic [31:0] rdata_d;
    logic        ack_q, ack_d, busy_q, busy_d;
    logic [47:0] prbs_q, prbs_d;
    logic [15:0] lfsr_q, lfsr_d;
    logic [13:0] len_q, len_d, pos_q, pos_d;
    logic [7:0]  inc_q, inc_d;
    etg_pkg::etg_state_t st_q, st_d;
    logic        wr, start, stop, f_ready, f_push, last;
    logic [7:0]  byte_v;
    etg_pkg::etg_word_t f_word, o_word;

    function automatic logic [31:0] wmask(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : wmask

    function automatic logic [7:0] octet(input logic [31:0] lo,
                                         input logic [15:0] hi,
                                         input logic [2:0]  k);
        logic [47:0] m;
        m = {hi, lo};
        return m[k*8 +: 8];
    endfunction : octet

    // bus slave: ack one cycle after the strobe; write lands on the ack edge
    assign wr    = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
    assign start = wr && wb_adr_i == `ETG_OFS_CTRL && wb_sel_i[0]
                   && wb_dat_i[`ETG_CTRL_START];
    assign stop  = wr && wb_adr_i == `ETG_OFS_CTRL && wb_sel_i[0]
                   && wb_dat_i[`ETG_CTRL_STOP];

    always_comb begin
        count_d = count_q;
        shape_d = shape_q;
        seedl_d = seedl_q;
        seedh_d = seedh_q;
        srcl_d  = srcl_q;
        srch_d  = srch_q;
        dstl_d  = dstl_q;
        dsth_d  = dsth_q;
        ack_d   = wb_cyc_i && wb_stb_i && !ack_q;
        rdata_d = `ETG_RST_WORD;
        if (wr) begin
            unique case (wb_adr_i)
                `ETG_OFS_COUNT:   count_d = wmask(count_q, wb_dat_i,
                                                  wb_sel_i);
                `ETG_OFS_SHAPE:   shape_d = 32'(16'(wmask(shape_q,
                                             wb_dat_i, wb_sel_i)));
                `ETG_OFS_SEED_LO: seedl_d = wmask(seedl_q, wb_dat_i,
                                                  wb_sel_i);
                `ETG_OFS_SEED_HI: seedh_d = 16'(wmask({16'h0000, seedh_q},
                                    wb_dat_i, wb_sel_i));
                `ETG_OFS_SRC_LO:  srcl_d = wmask(srcl_q, wb_dat_i,
                                                 wb_sel_i);
                `ETG_OFS_SRC_HI:  srch_d = 16'(wmask({16'h0000, srch_q},
                                   wb_dat_i, wb_sel_i));
                `ETG_OFS_DST_LO:  dstl_d = wmask(dstl_q, wb_dat_i,
                                                 wb_sel_i);
                `ETG_OFS_DST_HI:  dsth_d = 16'(wmask({16'h0000, dsth_q},
                                   wb_dat_i, wb_sel_i));
                default: ;
            endcase
        end
        unique case (wb_adr_i)
            `ETG_OFS_COUNT:   rdata_d = count_q;
            `ETG_OFS_SHAPE:   rdata_d = shape_q;
            `ETG_OFS_SEED_LO: rdata_d = seedl_q;
            `ETG_OFS_SEED_HI: rdata_d = {16'h0000, seedh_q};
            `ETG_OFS_SRC_LO:  rdata_d = srcl_q;
            `ETG_OFS_SRC_HI:  rdata_d = {16'h0000, srch_q};
            `ETG_OFS_DST_LO:  rdata_d = dstl_q;
            `ETG_OFS_DST_HI:  rdata_d = {16'h0000, dsth_q};
            `ETG_OFS_CTRL:    rdata_d = {29'h0, busy_q, 2'b00};
            `ETG_OFS_SENT:    rdata_d = sent_q;
            default:          rdata_d = `ETG_RST_WORD;
        endcase
    end

    // frame engine
    assign f_push = st_q != etg_pkg::ETG_IDLE;
    assign last   = pos_q == len_q - 14'h0001;

    always_comb begin
        byte_v = inc_q;
        if (st_q == etg_pkg::ETG_HDR) begin
            if (pos_q < 14'h0006) begin
                byte_v = octet(dstl_q, dsth_q, pos_q[2:0]);
            end else begin
                byte_v = octet(srcl_q, srch_q,
                               3'(pos_q - 14'h0006));
            end
        end else if (shape_q[`ETG_BIT_PAT_SEL]) begin
            byte_v = prbs_q[7:0];
        end
    end

    assign f_word = {byte_v, pos_q == 14'h0000, last};

    always_comb begin
        st_d   = st_q;
        busy_d = busy_q;
        sent_d = sent_q;
        pos_d  = pos_q;
        len_d  = len_q;
        inc_d  = inc_q;
        prbs_d = prbs_q;
        lfsr_d = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12]
                  ^ lfsr_q[10]};
        if (start && !busy_q) begin
            busy_d = 1'b1;
            sent_d = '0;
            prbs_d = {seedh_q, seedl_q};
        end
        unique case (st_q)
            etg_pkg::ETG_IDLE: begin
                if (busy_q && sent_q != count_q && !stop) begin
                    st_d  = etg_pkg::ETG_HDR;
                    pos_d = '0;
                    inc_d = '0;
                    if (shape_q[`ETG_BIT_LEN_SEL]) begin
                        len_d = `ETG_LEN_MIN
                            + 14'(lfsr_q % 16'(`ETG_LEN_RAND_SPAN));
                    end else begin
                        len_d = shape_q[14:1];
                    end
                end else if (busy_q && !start) begin
                    busy_d = 1'b0;
                end
            end
            etg_pkg::ETG_HDR, etg_pkg::ETG_PAY: begin
                if (f_ready) begin
                    pos_d = pos_q + 14'h0001;
                    if (st_q == etg_pkg::ETG_PAY) begin
                        inc_d  = inc_q + 8'h01;
                        prbs_d = {prbs_q[46:0], prbs_q[47] ^ prbs_q[46]
                                  ^ prbs_q[20] ^ prbs_q[19]};
                    end
                    if (last) begin
                        st_d   = etg_pkg::ETG_IDLE;
                        sent_d = sent_q + 32'h1;
                    end else if (pos_q == `ETG_HDR_BYTES - 14'h0001) begin
                        st_d = etg_pkg::ETG_PAY;
                    end
                end
            end
            default: st_d = etg_pkg::ETG_IDLE;
        endcase
        if (stop) begin
            busy_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= `ETG_RST_WORD;
            shape_q <= `ETG_RST_WORD;
            seedl_q <= `ETG_RST_WORD;
            seedh_q <= '0;
            srcl_q  <= `ETG_RST_WORD;
            srch_q  <= '0;
            dstl_q  <= `ETG_RST_WORD;
            dsth_q  <= '0;
            ack_q   <= 1'b0;
            wb_dat_o <= `ETG_RST_WORD;
            st_q    <= etg_pkg::ETG_IDLE;
            busy_q  <= 1'b0;
            sent_q  <= '0;
            pos_q   <= '0;
            len_q   <= `ETG_LEN_MIN;
            inc_q   <= '0;
            prbs_q  <= '0;
            lfsr_q  <= 16'h0001;
        end else begin
            count_q <= count_d;
            shape_q <= shape_d;
            seedl_q <= seedl_d;
            seedh_q <= seedh_d;
            srcl_q  <= srcl_d;
            srch_q  <= srch_d;
            dstl_q  <= dstl_d;
            dsth_q  <= dsth_d;
            ack_q   <= ack_d;
            wb_dat_o <= rdata_d;
            st_q    <= st_d;
            busy_q  <= busy_d;
            sent_q  <= sent_d;
            pos_q   <= pos_d;
            len_q   <= len_d;
            inc_q   <= inc_d;
            prbs_q  <= prbs_d;
            lfsr_q  <= lfsr_d;
        end
    end

    assign wb_ack_o  = ack_q;
    assign busy_o    = busy_q;
    assign tx_data_o = o_word[9:2];
    assign tx_sof_o  = o_word[1];
    assign tx_eof_o  = o_word[0];

    etg_fifo #(
        .WIDTH (10),
        .DEPTH (`ETG_FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (f_push),
        .in_ready_o  (f_ready),
        .in_data_i   (f_word),
        .out_valid_o (tx_valid_o),
        .out_ready_i (tx_ready_i),
        .out_data_o  (o_word)
    );

    count_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == etg_pkg::ETG_IDLE && busy_q && sent_q == count_q
        |=> st_q == etg_pkg::ETG_IDLE)
        else $error("frame started beyond count");
    sent_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        busy_q |-> sent_q <= count_q)
        else $error("sent exceeds count");
    rand_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q != etg_pkg::ETG_IDLE && shape_q[`ETG_BIT_LEN_SEL]
        && $past(st_q) == etg_pkg::ETG_IDLE
        |-> len_q >= `ETG_LEN_MIN && len_q <= `ETG_LEN_RAND_MAX)
        else $error("random length out of range");
    fix_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(st_q == etg_pkg::ETG_HDR) && !$past(shape_q[0])
        |-> len_q == $past(shape_q[14:1]))
        else $error("fixed length not taken");
    dst_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
        f_push && pos_q == 14'h0000 |-> byte_v == dstl_q[7:0])
        else $error("frame does not open with destination");
    src_next_a: assert property (@(posedge clk_i) disable iff (rst_i)
        f_push && pos_q == 14'h0006 |-> byte_v == srcl_q[7:0])
        else $error("source octet misplaced");
    inc_pay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == etg_pkg::ETG_PAY && pos_q == `ETG_HDR_BYTES
        && !shape_q[15] |-> byte_v == 8'h00)
        else $error("count pattern does not start at zero");
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    seed_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        start && !busy_q
        |=> prbs_q == {$past(seedh_q), $past(seedl_q)})
        else $error("seed not loaded");
    stop_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        stop |=> !busy_q)
        else $error("stop did not end the run");
    sent_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        busy_q && $past(busy_q) && $changed(sent_q)
        |-> sent_q == $past(sent_q) + 32'h1)
        else $error("sent count skipped a frame");
    idle_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !busy_q && st_q == etg_pkg::ETG_IDLE
        |=> st_q == etg_pkg::ETG_IDLE)
        else $error("frame started while not busy");
    dst_last_a: assert property (@(posedge clk_i) disable iff (rst_i)
        f_push && pos_q == 14'h0005 |-> byte_v == dsth_q[15:8])
        else $error("last destination octet misplaced");
    src_last_a: assert property (@(posedge clk_i) disable iff (rst_i)
        f_push && pos_q == 14'h000b |-> byte_v == srch_q[15:8])
        else $error("last source octet misplaced");
    pay_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == etg_pkg::ETG_PAY |-> pos_q >= `ETG_HDR_BYTES)
        else $error("payload before the header ended");
    frame_c: cover property (@(posedge clk_i) tx_valid_o && tx_eof_o
        && tx_ready_i);
    rand_c: cover property (@(posedge clk_i) f_push && shape_q[0]);
    stall_c: cover property (@(posedge clk_i) f_push && !f_ready);
    stop_c: cover property (@(posedge clk_i) stop && busy_q);
    hold_c: cover property (@(posedge clk_i) tx_valid_o
        && !tx_ready_i);
endmodule : etg_top

//--- verification/etg_mac_sink.sv
`timescale 1ns/1ps
// far-side mac: takes bytes at once, one cycle in four, or none at all
module etg_mac_sink (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // pacing
    input  wire logic slow_i,
    input  wire logic hold_i,
    // stream
    output logic      tx_ready_o
);
    logic [1:0] tick_q;
    logic [1:0] tick_d;
    logic       ready_d;
    always_comb begin
        tick_d  = tick_q + 2'h1;
        ready_d = !hold_i && (!slow_i || tick_q == 2'h0);
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_q     <= 2'h0;
            tx_ready_o <= 1'b0;
        end else begin
            tick_q     <= tick_d;
            tx_ready_o <= ready_d;
        end
    end
endmodule : etg_mac_sink

//--- verification/test_ethernet_test_frame_generator.sv
`timescale 1ns/1ps
`include "etg_regs.svh"
`define ETG_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
    miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module test_ethernet_test_frame_generator;
    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        wb_cyc   = 1'b0;
    logic        wb_stb   = 1'b0;
    logic        wb_we    = 1'b0;
    logic [7:0]  wb_adr   = 8'h00;
    logic [3:0]  wb_sel   = 4'h0;
    logic [31:0] wb_dat   = 32'h0;
    logic        slow     = 1'b0;
    logic        hold     = 1'b0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        tx_valid_o;
    logic        tx_ready;
    logic [7:0]  tx_data_o;
    logic        tx_sof_o;
    logic        tx_eof_o;
    logic        busy_o;
    logic [31:0] q;
    logic        pv_q     = 1'b0;
    logic        pr_q     = 1'b0;
    logic [9:0]  pd_q     = 10'h0;
    logic [9:0]  rx_q[$];
    logic [7:0]  ref_a[0:2047];
    logic [47:0] src_mac  = 48'hcb4a_1723_1c00;
    logic [47:0] dst_mac  = 48'h5044_3322_11ee;
    int          miscompares = 0;
    int          num_checks  = 0;

    always #25 clk_i = ~clk_i;

    etg_top u_etg_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready),
        .tx_data_o(tx_data_o), .tx_sof_o(tx_sof_o), .tx_eof_o(tx_eof_o),
        .busy_o(busy_o));
    etg_mac_sink u_etg_mac_sink (.clk_i(clk_i), .rst_i(rst_i),
        .slow_i(slow), .hold_i(hold), .tx_ready_o(tx_ready));

    // collect taken bytes; a stalled byte must hold still
    always @(posedge clk_i) begin
        if (!rst_i && pv_q === 1'b1 && pr_q !== 1'b1) begin
            `ETG_CHK({tx_valid_o, tx_sof_o, tx_eof_o, tx_data_o}, {1'b1, pd_q})
        end
        if (!rst_i && tx_valid_o === 1'b1 && tx_ready === 1'b1) begin
            rx_q.push_back({tx_sof_o, tx_eof_o, tx_data_o});
        end
        pv_q <= tx_valid_o;
        pr_q <= tx_ready;
        pd_q <= {tx_sof_o, tx_eof_o, tx_data_o};
    end

    task automatic wb_cycle(input logic [7:0] a, input logic w,
            input logic [3:0] s, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_sel <= s;
        wb_dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 64);
        if (wb_ack_o !== 1'b1) miscompares++;
        r = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb_cycle

    task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb_cycle(a, 1'b1, 4'hf, d, r);
    endtask : wb_write

    task automatic wb_read(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb_cycle(a, 1'b0, 4'hf, 32'h0, r);
        `ETG_CHK(r, e)
    endtask : wb_read

    task automatic run(input logic [31:0] cnt, input logic [31:0] shape,
            input int h);
        int n;
        n = 0;
        wb_write(`ETG_OFS_COUNT, cnt);
        wb_write(`ETG_OFS_SHAPE, shape);
        hold <= (h != 0);
        wb_write(`ETG_OFS_CTRL, 32'h0000_0001);
        repeat (h + 4) @(posedge clk_i);
        hold <= 1'b0;
        if (cnt != 0) `ETG_CHK(busy_o, 1'b1)
        if (cnt != 0) wb_read(`ETG_OFS_CTRL, 32'h0000_0004);
        do begin
            @(posedge clk_i);
            n++;
        end while ((busy_o !== 1'b0 || tx_valid_o !== 1'b0) && n < 40000);
        if (n >= 40000) miscompares++;
        repeat (4) @(posedge clk_i);
        wb_read(`ETG_OFS_SENT, cnt);
    endtask : run

    // mode 0 counting payload, 1 record and differ, 2 same, 3 differ
    task automatic check_frames(input int nfr, input int flen, input int mode);
        logic [9:0] b;
        logic [7:0] e;
        int         idx;
        int         diff;
        diff = 0;
        for (int f = 0; f < nfr; f++) begin
            idx = 0;
            do begin
                if (rx_q.size() == 0) begin
                    miscompares++;
                    return;
                end
                b = rx_q.pop_front();
                `ETG_CHK(b[9], idx == 0)
                if (idx < 12) e = idx < 6 ? dst_mac[8*idx +: 8]
                                          : src_mac[8*(idx-6) +: 8];
                else e = mode < 2 ? 8'(idx - 12) : ref_a[idx];
                if (mode == 1) ref_a[idx] = b[7:0];
                if (idx < 12 || mode % 2 == 0) `ETG_CHK(b[7:0], e)
                else if (b[7:0] !== e) diff++;
                idx++;
            end while (b[8] !== 1'b1 && idx < 9700);
            if (flen != 0) `ETG_CHK(idx, flen)
            else `ETG_CHK(idx >= 24 && idx <= 1518, 1'b1)
        end
        if (mode % 2 == 1) `ETG_CHK(diff != 0, 1'b1)
        `ETG_CHK(rx_q.size(), 0)
    endtask : check_frames

    task report_and_stop();
        if (miscompares == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (90000) @(posedge clk_i);
        miscompares++;
        report_and_stop();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) wb_read(8'(4 * i), 32'h0);
        for (int i = 0; i < 8; i++) begin
            wb_write(8'(4 * i), 32'hffff_ffff);
            wb_read(8'(4 * i), i % 2 ? 32'h0000_ffff : 32'hffff_ffff);
        end
        wb_write(8'h40, 32'h1234_5678);
        wb_read(8'h40, 32'h0);
        wb_cycle(`ETG_OFS_SRC_LO, 1'b1, 4'h4, 32'h5555_5555, q);
        wb_read(`ETG_OFS_SRC_LO, 32'hff55_ffff);
        wb_write(`ETG_OFS_SRC_LO, src_mac[31:0]);
        wb_write(`ETG_OFS_SRC_HI, {16'h0, src_mac[47:32]});
        wb_write(`ETG_OFS_DST_LO, dst_mac[31:0]);
        wb_write(`ETG_OFS_DST_HI, {16'h0, dst_mac[47:32]});
        slow <= 1'b1;
        run(32'h2, 32'h0000_0030, 0);
        check_frames(2, 24, 0);
        slow <= 1'b0;
        run(32'h1, 32'h0000_00c8, 60);
        check_frames(1, 100, 0);
        run(32'h0, 32'h0000_0060, 0);
        check_frames(0, 0, 0);
        slow <= 1'b1;
        run(32'h3, 32'h0000_4b01, 0);
        check_frames(3, 0, 0);
        slow <= 1'b0;
        wb_write(`ETG_OFS_SEED_LO, 32'h1234_5678);
        wb_write(`ETG_OFS_SEED_HI, 32'h0000_9abc);
        run(32'h1, 32'h0000_80c8, 0);
        check_frames(1, 100, 1);
        run(32'h1, 32'h0000_80c8, 0);
        check_frames(1, 100, 2);
        wb_write(`ETG_OFS_SEED_HI, 32'h0000_1111);
        run(32'h1, 32'h0000_80c8, 0);
        check_frames(1, 100, 3);
        wb_write(`ETG_OFS_COUNT, 32'h3);
        wb_write(`ETG_OFS_SHAPE, 32'h0000_0030);
        wb_write(`ETG_OFS_CTRL, 32'h0000_0001);
        wb_write(`ETG_OFS_CTRL, 32'h0000_0002);
        repeat (60) @(posedge clk_i);
        `ETG_CHK({busy_o, tx_valid_o}, 2'b00)
        wb_read(`ETG_OFS_CTRL, 32'h0);
        wb_read(`ETG_OFS_SENT, 32'h1);
        check_frames(1, 24, 0);
        report_and_stop();
    end
endmodule : test_ethernet_test_frame_generator
